// *** rtl/encoder_output_config.sv ***
`timescale 1ns/1ps
`default_nettype none
module encoder_output_config (
  input  wire logic        clock_in,
  input  wire logic        nrst_in,
  input  wire logic        frame_valid_in,
  input  wire logic [7:0]  frame_data_in,
  input  wire logic        frame_set_end_in,
  input  wire logic        variant_18mm_in,
  input  wire logic [7:0]  alarm_event_in,
  output logic             echo_valid_out,
  output logic [7:0]       echo_data_out,
  output logic             reply_valid_out,
  output logic [7:0]       reply_data_out,
  output logic             unlocked_out,
  output logic             nvm_enable_out,
  output logic             count_cw_out,
  output logic [1:0]       link_mode_out,
  output logic             half_duplex_position_link_out,
  output logic             half_duplex_fast_out,
  output logic [2:0]       node_id_out,
  output logic [5:0]       pole_pairs_out,
  output logic [8:0]       index_width_edeg_out,
  output logic [13:0]      counts_per_revolution_out,
  output logic [4:0]       abs_resolution_bits_out,
  output logic [17:0]      commutation_cycle_mdeg_out,
  output logic [14:0]      commutation_step_mdeg_out,
  output logic [23:0]      zero_position_out,
  output logic [7:0]       external_gain_trim_out,
  output logic [7:0]       phase_trim_out,
  output logic [5:0]       monitor_trim_out,
  output logic [5:0]       pin_routing_select_out,
  output logic             calibration_enable_out,
  output logic             output_function_enable_out,
  output logic [7:0]       alarm_flags_out,
  output logic             alarm_clear_out
);
  // ----------------------------------------
  // decode functions
  // ----------------------------------------
  function automatic logic [5:0] pairs_of(input logic [2:0] code);
    case (code)
      3'h0: pairs_of = 6'h02;
      3'h1: pairs_of = 6'h03;
      3'h2: pairs_of = 6'h04;
      3'h3: pairs_of = 6'h05;
      3'h4: pairs_of = 6'h0c;
      3'h5: pairs_of = 6'h1e;
      default: pairs_of = 6'h20;
    endcase
  endfunction

  function automatic logic [17:0] cycle_of(input logic [2:0] code);
    cycle_of = 18'(enc_cfg_pkg::MDEG_PER_TURN / int'(pairs_of(code)));
  endfunction

  function automatic logic [8:0] iwidth_of(input logic [1:0] code);
    case (code)
      2'h1: iwidth_of = 9'h0b4;
      2'h2: iwidth_of = 9'h168;
      default: iwidth_of = 9'h05a;
    endcase
  endfunction

  function automatic logic [13:0] cpr_of(input logic [2:0] code);
    if (code > 3'h5) begin
      cpr_of = 14'h0080;
    end else begin
      cpr_of = 14'(14'h2000 >> code);
    end
  endfunction

  function automatic logic [4:0] absbits_of(input logic [1:0] code, input logic short_body);
    case (code)
      2'h1: absbits_of = short_body ? 5'h13 : 5'h15;
      2'h2: absbits_of = short_body ? 5'h15 : 5'h11;
      default: absbits_of = 5'h11;
    endcase
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  unlock;
    logic [7:0]  gain;
    logic [7:0]  phase;
    logic [7:0]  link_dir;
    logic [7:0]  incr;
    logic [7:0]  resmon;
    logic [7:0]  zero_lo;
    logic [7:0]  zero_mid;
    logic [7:0]  zero_hi;
    logic [7:0]  probe;
    logic [7:0]  alarm_ctl;
    logic [7:0]  func;
    logic [7:0]  alarm_flags;
    logic        alarm_clear;
    logic [5:0]  pairs;
    logic [8:0]  iwidth;
    logic [13:0] counts_per_revolution;
    logic [4:0]  absbits;
    logic [17:0] cycle;
    logic [14:0] step;
  } cfg_s;

  localparam logic [2:0] RST_PAIRS_CODE = enc_cfg_pkg::RST_INCR[enc_cfg_pkg::PAIRS_LSB +: 3];
  localparam logic [17:0] RST_CYCLE = cycle_of(RST_PAIRS_CODE);
  localparam cfg_s STATE_INIT = '{
    unlock:      enc_cfg_pkg::RST_UNLOCK,
    link_dir:    enc_cfg_pkg::RST_LINK_DIR,
    incr:        enc_cfg_pkg::RST_INCR,
    resmon:      enc_cfg_pkg::RST_RESMON,
    alarm_flags: enc_cfg_pkg::RST_OTHER,
    pairs:       pairs_of(RST_PAIRS_CODE),
    iwidth:      iwidth_of(enc_cfg_pkg::RST_INCR[enc_cfg_pkg::IWIDTH_LSB +: 2]),
    counts_per_revolution:         cpr_of(enc_cfg_pkg::RST_INCR[enc_cfg_pkg::CPR_LSB +: 3]),
    absbits:     absbits_of(enc_cfg_pkg::RST_RESMON[enc_cfg_pkg::ABS_LSB +: 2], 1'b0),
    cycle:       RST_CYCLE,
    step:        15'(RST_CYCLE / 18'(enc_cfg_pkg::STEPS_PER_CYCLE)),
    default:     '0
  };

  cfg_s state_reg;
  cfg_s state_next;
  logic is_unlocked;
  logic cfg_write;
  logic clear_cmd;

  cfg_access_if acc ();

  cfg_frame_decoder frames (
    .clock_in         (clock_in),
    .nrst_in          (nrst_in),
    .frame_valid_in   (frame_valid_in),
    .frame_data_in    (frame_data_in),
    .frame_set_end_in (frame_set_end_in),
    .echo_valid_out   (echo_valid_out),
    .echo_data_out    (echo_data_out),
    .reply_valid_out  (reply_valid_out),
    .reply_data_out   (reply_data_out),
    .acc              (acc.decoder)
  );

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  assign is_unlocked = (state_reg.unlock == enc_cfg_pkg::UNLOCK_KEY);
  assign cfg_write = acc.wr && acc.page == enc_cfg_pkg::PAGE_CFG && is_unlocked;
  assign clear_cmd = cfg_write && acc.addr == enc_cfg_pkg::ADDR_ALARM &&
                     acc.wdata[enc_cfg_pkg::CLEAR_BIT];

  always_comb begin
    state_next = state_reg;
    if (acc.wr && acc.page == enc_cfg_pkg::PAGE_UNLOCK && acc.addr == enc_cfg_pkg::ADDR_UNLOCK) begin
      state_next.unlock = acc.wdata;
    end
    if (cfg_write) begin
      case (acc.addr)
        enc_cfg_pkg::ADDR_GAIN:     state_next.gain = acc.wdata;
        enc_cfg_pkg::ADDR_PHASE:    state_next.phase = acc.wdata;
        enc_cfg_pkg::ADDR_LINK_DIR: state_next.link_dir = acc.wdata;
        enc_cfg_pkg::ADDR_INCR:     state_next.incr = acc.wdata;
        enc_cfg_pkg::ADDR_RESMON:   state_next.resmon = acc.wdata;
        enc_cfg_pkg::ADDR_ZERO_LO:  state_next.zero_lo = acc.wdata;
        enc_cfg_pkg::ADDR_ZERO_MID: state_next.zero_mid = acc.wdata;
        enc_cfg_pkg::ADDR_ZERO_HI:  state_next.zero_hi = acc.wdata;
        enc_cfg_pkg::ADDR_PROBE:    state_next.probe = acc.wdata;
        enc_cfg_pkg::ADDR_ALARM:    state_next.alarm_ctl = {1'b0, acc.wdata[6:0]};
        enc_cfg_pkg::ADDR_FUNC:     state_next.func = acc.wdata;
        default:                    state_next.unlock = state_reg.unlock;
      endcase
    end
    // set wins over clear
    state_next.alarm_flags = (state_reg.alarm_flags & ~{8{clear_cmd}}) | alarm_event_in;
    state_next.alarm_clear = clear_cmd;
    // decoded settings, one cycle behind the bytes
    state_next.pairs = pairs_of(state_reg.incr[enc_cfg_pkg::PAIRS_LSB +: 3]);
    state_next.iwidth = iwidth_of(state_reg.incr[enc_cfg_pkg::IWIDTH_LSB +: 2]);
    state_next.counts_per_revolution = cpr_of(state_reg.incr[enc_cfg_pkg::CPR_LSB +: 3]);
    state_next.absbits = absbits_of(state_reg.resmon[enc_cfg_pkg::ABS_LSB +: 2], variant_18mm_in);
    state_next.cycle = cycle_of(state_reg.incr[enc_cfg_pkg::PAIRS_LSB +: 3]);
    state_next.step = 15'(state_next.cycle / 18'(enc_cfg_pkg::STEPS_PER_CYCLE));
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      state_reg <= STATE_INIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // read back
  // ----------------------------------------
  always_comb begin
    acc.rdata = 8'h00;
    if (acc.page == enc_cfg_pkg::PAGE_UNLOCK && acc.addr == enc_cfg_pkg::ADDR_UNLOCK) begin
      acc.rdata = state_reg.unlock;
    end else if (acc.page == enc_cfg_pkg::PAGE_CFG) begin
      case (acc.addr)
        enc_cfg_pkg::ADDR_GAIN:     acc.rdata = state_reg.gain;
        enc_cfg_pkg::ADDR_PHASE:    acc.rdata = state_reg.phase;
        enc_cfg_pkg::ADDR_LINK_DIR: acc.rdata = state_reg.link_dir;
        enc_cfg_pkg::ADDR_INCR:     acc.rdata = state_reg.incr;
        enc_cfg_pkg::ADDR_RESMON:   acc.rdata = state_reg.resmon;
        enc_cfg_pkg::ADDR_ZERO_LO:  acc.rdata = state_reg.zero_lo;
        enc_cfg_pkg::ADDR_ZERO_MID: acc.rdata = state_reg.zero_mid;
        enc_cfg_pkg::ADDR_ZERO_HI:  acc.rdata = state_reg.zero_hi;
        enc_cfg_pkg::ADDR_PROBE:    acc.rdata = state_reg.probe;
        enc_cfg_pkg::ADDR_ALARM:    acc.rdata = state_reg.alarm_ctl;
        enc_cfg_pkg::ADDR_FUNC:     acc.rdata = state_reg.func;
        default:                    acc.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign unlocked_out                  = is_unlocked;
  assign nvm_enable_out                = state_reg.link_dir[enc_cfg_pkg::NVM_BIT];
  assign count_cw_out                  = state_reg.link_dir[enc_cfg_pkg::DIR_BIT];
  assign link_mode_out                 = state_reg.link_dir[enc_cfg_pkg::LINK_LSB +: 2];
  assign half_duplex_position_link_out = (link_mode_out != enc_cfg_pkg::LINK_SSI);
  assign half_duplex_fast_out          = (link_mode_out == enc_cfg_pkg::LINK_HD_FAST);
  assign node_id_out                   = state_reg.link_dir[enc_cfg_pkg::NODE_LSB +: 3];
  assign pole_pairs_out                = state_reg.pairs;
  assign index_width_edeg_out          = state_reg.iwidth;
  assign counts_per_revolution_out     = state_reg.counts_per_revolution;
  assign abs_resolution_bits_out       = state_reg.absbits;
  assign commutation_cycle_mdeg_out    = state_reg.cycle;
  assign commutation_step_mdeg_out     = state_reg.step;
  assign zero_position_out             = {state_reg.zero_hi, state_reg.zero_mid, state_reg.zero_lo};
  assign external_gain_trim_out        = state_reg.gain;
  assign phase_trim_out                = state_reg.phase;
  assign monitor_trim_out              = state_reg.resmon[7:2];
  assign pin_routing_select_out        = state_reg.probe[5:0];
  assign calibration_enable_out        = state_reg.func[enc_cfg_pkg::CAL_BIT];
  assign output_function_enable_out    = state_reg.func[enc_cfg_pkg::FUNC_BIT];
  assign alarm_flags_out               = state_reg.alarm_flags;
  assign alarm_clear_out               = state_reg.alarm_clear;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  unlock_write_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    acc.wr && acc.page == enc_cfg_pkg::PAGE_UNLOCK && acc.addr == enc_cfg_pkg::ADDR_UNLOCK
    |=> state_reg.unlock == $past(acc.wdata) && unlocked_out == ($past(acc.wdata) == 8'hab))
    else $error("unlock register not written");

  lock_guard_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    acc.wr && acc.page == enc_cfg_pkg::PAGE_CFG && !unlocked_out
    |=> $stable(state_reg.link_dir) && $stable(state_reg.incr) && $stable(zero_position_out))
    else $error("locked store was changed");

  nvm_select_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    cfg_write && acc.addr == enc_cfg_pkg::ADDR_LINK_DIR |=> nvm_enable_out == $past(acc.wdata[7]))
    else $error("memory enable not taken");

  count_dir_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    cfg_write && acc.addr == enc_cfg_pkg::ADDR_LINK_DIR |=> count_cw_out == $past(acc.wdata[5]))
    else $error("direction not taken");

  link_mode_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    cfg_write && acc.addr == enc_cfg_pkg::ADDR_LINK_DIR && acc.wdata[4:3] == 2'h3
    |=> half_duplex_fast_out && half_duplex_position_link_out && node_id_out == $past(acc.wdata[2:0]))
    else $error("link mode or node id wrong");

  reset_default_a: assert property (@(posedge clock_in)
    $rose(nrst_in) |-> state_reg.link_dir == 8'h00 && state_reg.incr == 8'hc0 &&
    state_reg.resmon == 8'h3f && pole_pairs_out == 6'h20 && counts_per_revolution_out == 14'h2000)
    else $error("reset defaults wrong");

  pole_pairs_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    $stable(state_reg.incr) && state_reg.incr[7:5] == 3'h4 |=> pole_pairs_out == 6'h0c)
    else $error("pole pair decode wrong");

  index_width_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    $stable(state_reg.incr) && state_reg.incr[4:3] == 2'h2 |=> index_width_edeg_out == 9'h168)
    else $error("index width decode wrong");

  cpr_map_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    $stable(state_reg.incr) && state_reg.incr[2:0] == 3'h5 |=> counts_per_revolution_out == 14'h0100)
    else $error("count decode wrong");

  abs_bits_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    $stable(state_reg.resmon) && state_reg.resmon[1:0] == 2'h1
    |=> abs_resolution_bits_out == ($past(variant_18mm_in) ? 5'h13 : 5'h15))
    else $error("resolution decode wrong");

  zero_mid_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    cfg_write && acc.addr == enc_cfg_pkg::ADDR_ZERO_MID |=> zero_position_out[15:8] == $past(acc.wdata))
    else $error("zero position byte misplaced");

  alarm_clear_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    clear_cmd |=> alarm_clear_out && alarm_flags_out == $past(alarm_event_in) ##1 !alarm_clear_out)
    else $error("alarm clear wrong");

  comm_step_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    32'(commutation_step_mdeg_out) * 6 == 32'(commutation_cycle_mdeg_out) &&
    32'(commutation_cycle_mdeg_out) * 32'(pole_pairs_out) == 360000)
    else $error("commutation spacing wrong");

  func_enable_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    cfg_write && acc.addr == enc_cfg_pkg::ADDR_FUNC
    |=> calibration_enable_out == $past(acc.wdata[1]) && output_function_enable_out == $past(acc.wdata[5]))
    else $error("function enables not taken");

  alarm_set_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    1'b1 |=> (alarm_flags_out & $past(alarm_event_in)) == $past(alarm_event_in))
    else $error("alarm event not latched");

  alarm_hold_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !clear_cmd |=> (alarm_flags_out & $past(alarm_flags_out)) == $past(alarm_flags_out))
    else $error("alarm flag dropped without clear");

  cpr_floor_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    state_reg.incr[2:0] > 3'h5 |=> counts_per_revolution_out == 14'h0080)
    else $error("lowest count decode wrong");

  abs_small_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    state_reg.resmon[1:0] == 2'h2 |=> abs_resolution_bits_out == ($past(variant_18mm_in) ? 5'h15 : 5'h11))
    else $error("small body resolution wrong");

  zero_low_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    cfg_write && acc.addr == enc_cfg_pkg::ADDR_ZERO_LO |=> zero_position_out[7:0] == $past(acc.wdata))
    else $error("zero position low byte misplaced");
endmodule
`default_nettype wire

// *** include/enc_cfg_pkg.sv ***
`default_nettype none
package enc_cfg_pkg;
  // ----------------------------------------
  // pages and addresses
  // ----------------------------------------
  localparam logic [3:0] PAGE_UNLOCK   = 4'h8;
  localparam logic [3:0] PAGE_CFG      = 4'he;
  localparam logic [7:0] ADDR_UNLOCK   = 8'h00;
  localparam logic [7:0] ADDR_GAIN     = 8'h00;
  localparam logic [7:0] ADDR_PHASE    = 8'h08;
  localparam logic [7:0] ADDR_LINK_DIR = 8'h09;
  localparam logic [7:0] ADDR_INCR     = 8'h0a;
  localparam logic [7:0] ADDR_RESMON   = 8'h0b;
  localparam logic [7:0] ADDR_ZERO_LO  = 8'h0c;
  localparam logic [7:0] ADDR_ZERO_MID = 8'h0d;
  localparam logic [7:0] ADDR_ZERO_HI  = 8'h0e;
  localparam logic [7:0] ADDR_PROBE    = 8'h10;
  localparam logic [7:0] ADDR_ALARM    = 8'h14;
  localparam logic [7:0] ADDR_FUNC     = 8'h19;
  localparam logic [7:0] UNLOCK_KEY    = 8'hab;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int NVM_BIT     = 7;
  localparam int DIR_BIT     = 5;
  localparam int LINK_LSB    = 3;
  localparam int NODE_LSB    = 0;
  localparam int PAIRS_LSB   = 5;
  localparam int IWIDTH_LSB  = 3;
  localparam int CPR_LSB     = 0;
  localparam int ABS_LSB     = 0;
  localparam int CLEAR_BIT   = 7;
  localparam int CAL_BIT     = 1;
  localparam int FUNC_BIT    = 5;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_UNLOCK   = 8'h00;
  localparam logic [7:0] RST_LINK_DIR = 8'h00;
  localparam logic [7:0] RST_INCR     = 8'hc0;
  localparam logic [7:0] RST_RESMON   = 8'h3f;
  localparam logic [7:0] RST_OTHER    = 8'h00;
  // ----------------------------------------
  // link codes, commands, geometry
  // ----------------------------------------
  localparam logic [1:0] LINK_SSI     = 2'h0;
  localparam logic [1:0] LINK_HD_SLOW = 2'h1;
  localparam logic [1:0] LINK_HD_FAST = 2'h3;
  localparam logic [3:0] CMD_WRITE    = 4'h1;
  localparam logic [3:0] CMD_READ     = 4'h2;
  localparam int MDEG_PER_TURN = 360000;
  localparam int STEPS_PER_CYCLE = 6;
endpackage
`default_nettype wire

// *** include/cfg_access_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface cfg_access_if;
  logic       wr;
  logic       rd;
  logic [3:0] page;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport decoder (output wr, rd, page, addr, wdata, input rdata);
  modport regs    (input wr, rd, page, addr, wdata, output rdata);
endinterface
`default_nettype wire

// *** rtl/cfg_frame_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module cfg_frame_decoder (
  input  wire logic       clock_in,
  input  wire logic       nrst_in,
  input  wire logic       frame_valid_in,
  input  wire logic [7:0] frame_data_in,
  input  wire logic       frame_set_end_in,
  output logic            echo_valid_out,
  output logic [7:0]      echo_data_out,
  output logic            reply_valid_out,
  output logic [7:0]      reply_data_out,
  cfg_access_if.decoder   acc
);
  typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_VALUE, PH_CHECK} phase_e;
  typedef struct packed {
    phase_e     phase;
    logic [7:0] cmd;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] chk;
    logic       wr;
    logic       rd;
    logic       echo;
    logic       reply;
    logic [7:0] rdata;
  } dec_s;
  dec_s state_reg;
  dec_s state_next;
  // ----------------------------------------
  // frame set parser
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.wr = 1'b0;
    state_next.rd = 1'b0;
    state_next.echo = 1'b0;
    state_next.reply = state_reg.rd;
    if (state_reg.rd) begin
      state_next.rdata = acc.rdata;
    end
    if (frame_set_end_in) begin
      state_next.phase = PH_IDLE;
    end else if (frame_valid_in) begin
      case (state_reg.phase)
        PH_IDLE: begin
          if (frame_data_in[7:4] == enc_cfg_pkg::CMD_WRITE ||
              frame_data_in[7:4] == enc_cfg_pkg::CMD_READ) begin
            state_next.cmd = frame_data_in;
            state_next.chk = frame_data_in;
            state_next.echo = 1'b1;
            state_next.phase = PH_ADDR;
          end
        end
        PH_ADDR: begin
          state_next.addr = frame_data_in;
          state_next.chk = state_reg.chk ^ frame_data_in;
          state_next.phase = (state_reg.cmd[7:4] == enc_cfg_pkg::CMD_WRITE) ? PH_VALUE : PH_CHECK;
        end
        PH_VALUE: begin
          state_next.data = frame_data_in;
          state_next.chk = state_reg.chk ^ frame_data_in;
          state_next.phase = PH_CHECK;
        end
        PH_CHECK: begin
          if (frame_data_in == state_reg.chk) begin
            state_next.wr = (state_reg.cmd[7:4] == enc_cfg_pkg::CMD_WRITE);
            state_next.rd = (state_reg.cmd[7:4] == enc_cfg_pkg::CMD_READ);
          end
          state_next.phase = PH_IDLE;
        end
        default: state_next.phase = PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      state_reg <= '{phase: PH_IDLE, default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign acc.wr          = state_reg.wr;
  assign acc.rd          = state_reg.rd;
  assign acc.page        = state_reg.cmd[3:0];
  assign acc.addr        = state_reg.addr;
  assign acc.wdata       = state_reg.data;
  assign echo_valid_out  = state_reg.echo;
  assign echo_data_out   = state_reg.cmd;
  assign reply_valid_out = state_reg.reply;
  assign reply_data_out  = state_reg.rdata;

  echo_frame_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    frame_valid_in && !frame_set_end_in && state_reg.phase == PH_IDLE &&
    frame_data_in[7:4] == enc_cfg_pkg::CMD_WRITE
    |=> echo_valid_out && echo_data_out == $past(frame_data_in) ##1 !echo_valid_out)
    else $error("command frame not echoed");
endmodule
`default_nettype wire

// *** verification/link_master.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// controller side of the frame link
// ----------------------------------------
module link_master (
  input  wire logic       clock_in,
  input  wire logic       go_in,
  input  wire logic       rd_in,
  input  wire logic [7:0] cmd_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] val_in,
  output logic            valid_out,
  output logic [7:0]      data_out,
  output logic            busy_out
);
  logic [7:0] seq [4];
  initial begin
    valid_out = 1'b0;
    data_out  = 8'h00;
    busy_out  = 1'b0;
    forever begin
      @(posedge clock_in);
      if (go_in) begin
        seq = '{cmd_in, addr_in, val_in, cmd_in ^ addr_in ^ val_in};
        for (int n = 0; n < 4; n++) begin
          if (!(rd_in && n == 2)) begin
            #1 valid_out = 1'b1;
            data_out  = seq[n];
            busy_out  = 1'b1;
            @(posedge clock_in);
          end
        end
        #1 valid_out = 1'b0;
        data_out = ~data_out;
        busy_out = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, nrst, go, rd, var18, fv, busy;
  logic [7:0] cmd, addr, val, alarm, fd;
  int err_count = 0;
  int checked = 0;
  int n_echo = 0;
  int n_reply = 0;
  int n_clear = 0;
  always @(posedge clk) begin
    if (dut.echo_valid_out === 1'b1) n_echo++;
    if (dut.reply_valid_out === 1'b1) n_reply++;
    if (dut.alarm_clear_out === 1'b1) n_clear++;
  end
  typedef struct packed {logic [7:0] v; logic [5:0] p; logic [8:0] w; logic [13:0] c;} row_s;
  row_s rows [8] = '{'{8'h00, 6'h02, 9'h05a, 14'h2000}, '{8'h29, 6'h03, 9'h0b4, 14'h1000},
                     '{8'h52, 6'h04, 9'h168, 14'h0800}, '{8'h7b, 6'h05, 9'h05a, 14'h0400},
                     '{8'h84, 6'h0c, 9'h05a, 14'h0200}, '{8'ha5, 6'h1e, 9'h05a, 14'h0100},
                     '{8'hde, 6'h20, 9'h05a, 14'h0080}, '{8'hff, 6'h20, 9'h05a, 14'h0080}};
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  link_master partner (.clock_in(clk), .go_in(go), .rd_in(rd), .cmd_in(cmd), .addr_in(addr),
    .val_in(val), .valid_out(fv), .data_out(fd), .busy_out(busy));
  encoder_output_config dut (.clock_in(clk), .nrst_in(nrst), .frame_valid_in(fv), .frame_data_in(fd),
    .frame_set_end_in(~busy), .variant_18mm_in(var18), .alarm_event_in(alarm), .echo_valid_out(),
    .echo_data_out(), .reply_valid_out(), .reply_data_out(), .unlocked_out(), .nvm_enable_out(),
    .count_cw_out(), .link_mode_out(), .half_duplex_position_link_out(), .half_duplex_fast_out(),
    .node_id_out(), .pole_pairs_out(), .index_width_edeg_out(), .counts_per_revolution_out(),
    .abs_resolution_bits_out(), .commutation_cycle_mdeg_out(), .commutation_step_mdeg_out(),
    .zero_position_out(), .external_gain_trim_out(), .phase_trim_out(), .monitor_trim_out(),
    .pin_routing_select_out(), .calibration_enable_out(), .output_function_enable_out(),
    .alarm_flags_out(), .alarm_clear_out());
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic r, input logic [3:0] pg, input logic [7:0] a, input logic [7:0] v);
    int i;
    @(posedge clk);
    #1 go = 1'b1;
    rd = r;
    cmd = {r ? 4'h2 : 4'h1, pg};
    addr = a;
    val = v;
    @(posedge clk);
    #1 go = 1'b0;
    @(posedge clk);
    for (i = 0; i < 10 && busy !== 1'b0; i++) @(posedge clk);
    if (i == 10) begin
      err_count++;
      tally_and_finish();
    end
    repeat (4) @(posedge clk);
  endtask
  initial begin
    {nrst, go, rd, var18, cmd, addr, val, alarm} = '0;
    repeat (16) @(posedge clk);
    #1 nrst = 1'b1;
    @(posedge clk);
    chk(dut.unlocked_out, 24'h0);
    chk({dut.pole_pairs_out, dut.index_width_edeg_out}, {6'h20, 9'h05a});
    chk(dut.counts_per_revolution_out, 24'h2000);
    chk(dut.commutation_cycle_mdeg_out, 24'h02bf2);
    chk(dut.commutation_step_mdeg_out, 24'h753);
    chk(dut.abs_resolution_bits_out, 24'h11);
    $display("test reset done");
    xfer(1'b0, 4'he, 8'h09, 8'hbd);
    chk(dut.count_cw_out, 24'h0);
    xfer(1'b0, 4'h8, 8'h00, 8'hab);
    chk(dut.unlocked_out, 24'h1);
    $display("test unlock done");
    for (int k = 0; k < 8; k++) begin
      xfer(1'b0, 4'he, 8'h0a, rows[k].v);
      chk(dut.pole_pairs_out, rows[k].p);
      chk(dut.index_width_edeg_out, rows[k].w);
      chk(dut.counts_per_revolution_out, rows[k].c);
    end
    $display("test rows done");
    xfer(1'b0, 4'he, 8'h09, 8'hbd);
    chk({dut.nvm_enable_out, dut.count_cw_out}, 24'h3);
    chk({dut.link_mode_out, dut.half_duplex_position_link_out, dut.half_duplex_fast_out}, 24'hf);
    chk(dut.node_id_out, 24'h5);
    xfer(1'b0, 4'he, 8'h0c, 8'h11);
    xfer(1'b0, 4'he, 8'h0d, 8'h22);
    xfer(1'b0, 4'he, 8'h0e, 8'h33);
    chk(dut.zero_position_out, 24'h332211);
    xfer(1'b1, 4'he, 8'h0d, 8'h00);
    chk(dut.reply_data_out, 24'h22);
    chk(dut.echo_data_out, 24'h2e);
    $display("test link and zero done");
    #1 alarm = 8'h05;
    @(posedge clk);
    #1 alarm = 8'h00;
    @(posedge clk);
    chk(dut.alarm_flags_out, 24'h05);
    xfer(1'b0, 4'he, 8'h14, 8'h80);
    chk(dut.alarm_flags_out, 24'h00);
    xfer(1'b0, 4'he, 8'h0b, 8'h01);
    chk(dut.abs_resolution_bits_out, 24'h15);
    #1 var18 = 1'b1;
    repeat (3) @(posedge clk);
    chk(dut.abs_resolution_bits_out, 24'h13);
    xfer(1'b0, 4'he, 8'h0b, 8'hfe);
    chk({dut.monitor_trim_out, dut.abs_resolution_bits_out}, 24'h7f5);
    xfer(1'b1, 4'he, 8'h14, 8'h00);
    chk(dut.reply_data_out, 24'h00);
    $display("test alarm and resolution done");
    xfer(1'b0, 4'he, 8'h09, 8'h08);
    chk({dut.half_duplex_position_link_out, dut.half_duplex_fast_out, dut.link_mode_out}, 24'h9);
    xfer(1'b0, 4'he, 8'h19, 8'h22);
    chk({dut.calibration_enable_out, dut.output_function_enable_out}, 24'h3);
    xfer(1'b0, 4'he, 8'h10, 8'hff);
    chk(dut.pin_routing_select_out, 24'h3f);
    xfer(1'b0, 4'he, 8'h00, 8'h5a);
    xfer(1'b0, 4'he, 8'h08, 8'hc3);
    chk({dut.external_gain_trim_out, dut.phase_trim_out}, 24'h5ac3);
    chk(n_echo, 24'h18);
    chk(n_reply, 24'h2);
    chk(n_clear, 24'h1);
    $display("test outputs and pulses done");
    #1 nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    @(posedge clk);
    chk({dut.unlocked_out, dut.node_id_out, dut.link_mode_out}, 24'h0);
    chk(dut.zero_position_out, 24'h0);
    chk(dut.counts_per_revolution_out, 24'h2000);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
